// ### logic/agc_pkg.sv
// constants for the adc gain control block
`default_nettype none
package agc_pkg;
  // ------------------------------------------------------------------
  // control word and register map
  // ------------------------------------------------------------------
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 9;
  localparam int DATA_W  = 9;
  localparam logic [6:0] OFF_LEFT_GAIN  = 7'h0e;
  localparam logic [6:0] OFF_RIGHT_GAIN = 7'h0f;
  localparam logic [6:0] OFF_CFG_ONE    = 7'h10;
  localparam logic [6:0] OFF_CFG_TWO    = 7'h11;
  localparam logic [6:0] OFF_TIMING     = 7'h12;
  localparam logic [6:0] OFF_ATTEN_CAP  = 7'h14;
  localparam logic [6:0] OFF_SOFT_RESET = 7'h17;
  localparam logic [8:0] RST_LEFT_GAIN  = 9'h0cf;
  localparam logic [8:0] RST_RIGHT_GAIN = 9'h0cf;
  localparam logic [8:0] RST_CFG_ONE    = 9'h1fe;
  localparam logic [8:0] RST_CFG_TWO    = 9'h180;
  localparam logic [8:0] RST_TIMING     = 9'h092;
  localparam logic [8:0] RST_ATTEN_CAP  = 9'h006;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int SEL_HI = 8;
  localparam int SEL_LO = 7;
  localparam int CEIL_HI = 6;
  localparam int CEIL_LO = 4;
  localparam int LVL_HI = 3;
  localparam int LVL_LO = 0;
  localparam int MODE_BIT = 8;
  localparam int ZC_BIT = 7;
  localparam int DCY_HI = 7;
  localparam int DCY_LO = 4;
  localparam int ATK_HI = 3;
  localparam int ATK_LO = 0;
  localparam int FLOOR_HI = 3;
  localparam int FLOOR_LO = 0;
  localparam int CODE_HI = 7;
  // ------------------------------------------------------------------
  // gain code scale (0.5 dB per code)
  // ------------------------------------------------------------------
  localparam logic [7:0] CODE_MIN_PGA = 8'ha5;
  localparam logic [7:0] CODE_MAX_PGA = 8'hff;
  localparam logic [7:0] CODE_0DB     = 8'hcf;
  localparam logic [7:0] CEIL_STEP    = 8'h08;
  localparam logic [3:0] LVL_CLAMP_ALC = 4'hd;
  localparam logic [3:0] TIME_SAT      = 4'h9;
  localparam logic [3:0] FLOOR_MIN     = 4'h3;
  localparam logic [1:0] SEL_RIGHT = 2'b01;
  localparam logic [1:0] SEL_LEFT  = 2'b10;
  // ------------------------------------------------------------------
  // timing (ns) and step intervals at 40 MHz
  // ------------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam longint ATK_ALC_NS = 8400000;
  localparam longint ATK_LIM_NS = 250000;
  localparam longint DCY_ALC_NS = 33600000;
  localparam longint DCY_LIM_NS = 1200000;
  localparam int ALC_SPAN_STEPS = 82;
  localparam int LIM_SPAN_STEPS = 12;
  localparam int ZC_TIMEOUT_CYC = 131072;
  localparam int ATK_ALC_STEP = int'(ATK_ALC_NS / (CLK_NS * ALC_SPAN_STEPS));
  localparam int ATK_LIM_STEP = int'(ATK_LIM_NS / (CLK_NS * LIM_SPAN_STEPS));
  localparam int DCY_ALC_STEP = int'(DCY_ALC_NS / (CLK_NS * ALC_SPAN_STEPS));
  localparam int DCY_LIM_STEP = int'(DCY_LIM_NS / (CLK_NS * LIM_SPAN_STEPS));
  localparam int TICK_W = 36;

  typedef enum logic [1:0] {
    AGC_HOLD = 2'b00,
    AGC_DOWN = 2'b01,
    AGC_UP   = 2'b10
  } agc_dir_type;
endpackage
`default_nettype wire

// ### logic/agc_channel.sv
// one channel of gain stepping with zero-cross gating
`timescale 1ns/10ps
`default_nettype none
module agc_channel #(
  parameter int TICK_W  = 36,
  parameter int TO_CYC  = 131072
) (
  input  wire logic              clk_sys_in,     // system clock
  input  wire logic              resetn_in,      // async reset, low
  input  wire logic              active_in,      // channel under control
  input  wire logic              alc_in,         // 1 = alc, 0 = limiter
  input  wire agc_pkg::agc_dir_type dir_in,      // wanted direction
  input  wire logic [TICK_W-1:0] interval_in,    // one less than cycles per step
  input  wire logic [7:0]        static_in,      // software gain code
  input  wire logic [7:0]        hi_in,          // upper bound
  input  wire logic [7:0]        lo_in,          // lower bound
  input  wire logic              zc_gate_in,     // wait for zero cross
  input  wire logic              zc_in,          // zero cross seen
  input  wire logic              to_dis_in,      // timeout disabled
  output logic [7:0]             gain_out        // applied gain code
);
  import agc_pkg::*;

  logic [7:0]        gain_r, gain_nxt, pend_r, pend_nxt;
  logic [TICK_W-1:0] tick_r, tick_nxt;
  logic [17:0]       to_r, to_nxt;
  logic              active_q_r;

  always_comb begin
    gain_nxt = gain_r;
    pend_nxt = pend_r;
    tick_nxt = tick_r;
    to_nxt   = to_r;
    if (!active_in) begin
      tick_nxt = '0;
      to_nxt   = '0;
      pend_nxt = gain_r;
    end else begin
      if (dir_in == AGC_HOLD || tick_r >= interval_in) begin
        tick_nxt = '0;
      end else begin
        tick_nxt = tick_r + 1'b1;
      end
      if (tick_r >= interval_in) begin
        if (dir_in == AGC_DOWN && pend_r > lo_in) begin
          pend_nxt = pend_r - 8'h01;
        end else if (dir_in == AGC_UP && pend_r < hi_in) begin
          pend_nxt = pend_r + 8'h01;
        end
      end
      if (pend_nxt > hi_in) begin
        pend_nxt = hi_in;
      end
      if (pend_nxt < lo_in) begin
        pend_nxt = lo_in;
      end
      if (!(alc_in && zc_gate_in)) begin
        gain_nxt = pend_nxt;
        to_nxt   = '0;
      end else if (pend_r != gain_r) begin
        if (zc_in || (!to_dis_in && to_r >= 18'(TO_CYC - 1))) begin
          gain_nxt = pend_r;
          to_nxt   = '0;
        end else begin
          to_nxt = to_r + 18'h00001;
        end
      end else begin
        to_nxt = '0;
      end
    end
  end

  // static code loaded when control takes over
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gain_r     <= CODE_0DB;
      pend_r     <= CODE_0DB;
      tick_r     <= '0;
      to_r       <= '0;
      active_q_r <= 1'b0;
    end else begin
      active_q_r <= active_in;
      tick_r     <= tick_nxt;
      to_r       <= to_nxt;
      if (active_in && !active_q_r) begin
        gain_r <= static_in;
        pend_r <= static_in;
      end else begin
        gain_r <= gain_nxt;
        pend_r <= pend_nxt;
      end
    end
  end

  // static shown in the load cycle, else a stale code leaks out once
  assign gain_out = (active_in && !active_q_r) ? static_in : gain_r;
endmodule
`default_nettype wire

// ### logic/agc_top.sv
// limiter / alc gain control with its register file
//
// Operation
// - limiter: peak above threshold steps pga gain down at attack rate
// - limiter: peak below threshold steps gain back up at decay rate
// - limiter never raises gain above the programmed static gain
// - alc: gain moves up or down to hold peak at target
// - function select bit: 0 alc, 1 limiter, reset 1
// - channel select: 00 off, 01 right, 10 left, 11 both
// - uncontrolled channel uses its own gain register
// - level field: 1.5 dB steps, -22.5 to 0 dB FS, reset 1110
// - alc targets -1.5 or 0 dB act as -3 dB
// - when disabled last gain holds; software sets fixed gain
// - decay is ramp-up time: 90% range alc, 6 dB limiter
// - attack is ramp-down time: 90% range alc, 6 dB limiter
// - attack doubles per code, saturating at code 1010
// - decay doubles per code, saturating at code 1010
// - alc zero-cross enable gates gain changes, reset 1
// - gain ceiling field caps alc gain, 4 dB steps, not limiter
// - attenuation floor caps limiter cut below static, not alc
// - any write to soft reset address restores register defaults
// - gain codes span +24 to -21 dB in 0.5 dB steps
// - pending zero-cross update forced after 131072 cycles
`timescale 1ns/10ps
`default_nettype none
module agc_top #(
  parameter int TO_CYC = agc_pkg::ZC_TIMEOUT_CYC
) (
  input  wire logic        clk_sys_in,       // 40 mhz system clock
  input  wire logic        resetn_in,        // async reset, low
  input  wire logic [15:0] ctrl_word_in,     // control word
  input  wire logic        ctrl_strobe_in,   // one-cycle write strobe
  input  wire logic [23:0] peak_left_in,     // left adc peak magnitude
  input  wire logic [23:0] peak_right_in,    // right adc peak magnitude
  input  wire logic        zc_left_in,       // left zero cross pulse
  input  wire logic        zc_right_in,      // right zero cross pulse
  input  wire logic        to_dis_in,        // zero-cross timeout off
  output logic [7:0]       left_gain_code_out,  // left pga gain code
  output logic [7:0]       right_gain_code_out, // right pga gain code
  output logic [8:0]       cfg_one_out,      // config one readback
  output logic [8:0]       cfg_two_out       // config two readback
);
  import agc_pkg::*;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [8:0] lgain_r, rgain_r, cfg1_r, cfg2_r, tim_r, cap_r;
  logic [8:0] lgain_nxt, rgain_nxt, cfg1_nxt, cfg2_nxt, tim_nxt, cap_nxt;
  logic [6:0] addr;
  logic [8:0] wdata;

  assign addr  = ctrl_word_in[ADDR_HI:ADDR_LO];
  assign wdata = ctrl_word_in[DATA_W-1:0];

  always_comb begin
    lgain_nxt = lgain_r;
    rgain_nxt = rgain_r;
    cfg1_nxt  = cfg1_r;
    cfg2_nxt  = cfg2_r;
    tim_nxt   = tim_r;
    cap_nxt   = cap_r;
    if (ctrl_strobe_in) begin
      case (addr)
        OFF_LEFT_GAIN:  lgain_nxt = wdata;
        OFF_RIGHT_GAIN: rgain_nxt = wdata;
        OFF_CFG_ONE:    cfg1_nxt  = wdata;
        OFF_CFG_TWO:    cfg2_nxt  = wdata;
        OFF_TIMING:     tim_nxt   = wdata;
        OFF_ATTEN_CAP:  cap_nxt   = wdata;
        OFF_SOFT_RESET: begin
          lgain_nxt = RST_LEFT_GAIN;
          rgain_nxt = RST_RIGHT_GAIN;
          cfg1_nxt  = RST_CFG_ONE;
          cfg2_nxt  = RST_CFG_TWO;
          tim_nxt   = RST_TIMING;
          cap_nxt   = RST_ATTEN_CAP;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lgain_r <= RST_LEFT_GAIN;
      rgain_r <= RST_RIGHT_GAIN;
      cfg1_r  <= RST_CFG_ONE;
      cfg2_r  <= RST_CFG_TWO;
      tim_r   <= RST_TIMING;
      cap_r   <= RST_ATTEN_CAP;
    end else begin
      lgain_r <= lgain_nxt;
      rgain_r <= rgain_nxt;
      cfg1_r  <= cfg1_nxt;
      cfg2_r  <= cfg2_nxt;
      tim_r   <= tim_nxt;
      cap_r   <= cap_nxt;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic [1:0] gain_channel_select;
  logic [3:0] threshold_target_level, ramp_down_time, ramp_up_time;
  logic [3:0] attenuation_floor;
  logic [2:0] gain_ceiling;
  logic       gain_function_select, auto_zero_cross_enable, alc_mode;

  assign gain_channel_select    = cfg1_r[SEL_HI:SEL_LO];
  assign gain_ceiling           = cfg1_r[CEIL_HI:CEIL_LO];
  assign threshold_target_level = cfg1_r[LVL_HI:LVL_LO];
  assign gain_function_select   = cfg2_r[MODE_BIT];
  assign auto_zero_cross_enable = cfg2_r[ZC_BIT];
  assign ramp_up_time           = tim_r[DCY_HI:DCY_LO];
  assign ramp_down_time         = tim_r[ATK_HI:ATK_LO];
  assign attenuation_floor      = cap_r[FLOOR_HI:FLOOR_LO];
  assign alc_mode = ~gain_function_select;

  function automatic logic [TICK_W-1:0] step_interval(
    input int base, input logic [3:0] code);
    logic [3:0] c;
    c = (code > TIME_SAT) ? 4'(TIME_SAT + 4'h1) : code;
    return TICK_W'(base) << c;
  endfunction

  // peak threshold from level code, 1.5 dB per code
  function automatic logic [23:0] level_thresh(input logic [3:0] code);
    logic [23:0] t;
    t = 24'h7fffff;
    // approx: each 2 codes is 3 dB (halve per 4 codes = 6 dB)
    t = t >> ((4'hf - code) >> 2);
    if (code[1:0] != 2'b11) begin
      t = t - (t >> 2'd3) * 24'(2'd3 - code[1:0]);
    end
    return t;
  endfunction

  logic [3:0]        lvl_eff;
  logic [23:0]       thresh;
  logic [TICK_W-1:0] atk_int, dcy_int;

  always_comb begin
    lvl_eff = threshold_target_level;
    // clamp high alc targets to -3 dB
    if (alc_mode && lvl_eff > LVL_CLAMP_ALC) begin
      lvl_eff = LVL_CLAMP_ALC;
    end
  end

  assign thresh = level_thresh(lvl_eff);
  assign atk_int = alc_mode ? step_interval(ATK_ALC_STEP, ramp_down_time)
                            : step_interval(ATK_LIM_STEP, ramp_down_time);
  assign dcy_int = alc_mode ? step_interval(DCY_ALC_STEP, ramp_up_time)
                            : step_interval(DCY_LIM_STEP, ramp_up_time);

  // alc ceiling: 111 = +24 dB, 4 dB per code, 001/000 = 0 dB
  logic [7:0] ceil_code;
  always_comb begin
    if (gain_ceiling <= 3'b001) begin
      ceil_code = CODE_0DB;
    end else begin
      ceil_code = 8'(CODE_MAX_PGA - CEIL_STEP * 8'(3'b111 - gain_ceiling));
    end
  end

  // limiter floor below static, 2 codes per dB
  logic [7:0] floor_steps;
  assign floor_steps = (attenuation_floor <= FLOOR_MIN)
                     ? 8'h06 : 8'({attenuation_floor, 1'b0});

  function automatic logic [7:0] floor_code(input logic [7:0] st,
                                            input logic [7:0] steps);
    logic [8:0] d;
    d = {1'b0, st} - {1'b0, steps};
    return (d[8] || d[7:0] < CODE_MIN_PGA) ? CODE_MIN_PGA : d[7:0];
  endfunction

  // ----------------------------------------------------------------
  // per-channel direction and bounds
  // ----------------------------------------------------------------
  logic        act_l, act_r;
  agc_dir_type dir_l, dir_r;
  logic [7:0]  hi_l, hi_r, lo_l, lo_r, st_l, st_r;
  logic [TICK_W-1:0] int_l, int_r;
  logic [7:0]  g_l, g_r;

  assign act_l = gain_channel_select[1];
  assign act_r = gain_channel_select[0];
  assign st_l  = lgain_r[CODE_HI:0];
  assign st_r  = rgain_r[CODE_HI:0];

  function automatic agc_dir_type pick_dir(input logic [23:0] pk,
                                           input logic [23:0] th);
    return (pk > th) ? AGC_DOWN : AGC_UP;
  endfunction

  assign dir_l = pick_dir(peak_left_in, thresh);
  assign dir_r = pick_dir(peak_right_in, thresh);
  assign int_l = (dir_l == AGC_DOWN) ? atk_int : dcy_int;
  assign int_r = (dir_r == AGC_DOWN) ? atk_int : dcy_int;
  // limiter tops at static; alc within pga range
  assign hi_l = alc_mode ? ceil_code : st_l;
  assign hi_r = alc_mode ? ceil_code : st_r;
  assign lo_l = alc_mode ? CODE_MIN_PGA : floor_code(st_l, floor_steps);
  assign lo_r = alc_mode ? CODE_MIN_PGA : floor_code(st_r, floor_steps);

  agc_channel #(.TICK_W(TICK_W), .TO_CYC(TO_CYC)) u_left (
    .clk_sys_in  (clk_sys_in),
    .resetn_in   (resetn_in),
    .active_in   (act_l),
    .alc_in      (alc_mode),
    .dir_in      (dir_l),
    .interval_in (int_l),
    .static_in   (st_l),
    .hi_in       (hi_l),
    .lo_in       (lo_l),
    .zc_gate_in  (auto_zero_cross_enable),
    .zc_in       (zc_left_in),
    .to_dis_in   (to_dis_in),
    .gain_out    (g_l)
  );

  agc_channel #(.TICK_W(TICK_W), .TO_CYC(TO_CYC)) u_right (
    .clk_sys_in  (clk_sys_in),
    .resetn_in   (resetn_in),
    .active_in   (act_r),
    .alc_in      (alc_mode),
    .dir_in      (dir_r),
    .interval_in (int_r),
    .static_in   (st_r),
    .hi_in       (hi_r),
    .lo_in       (lo_r),
    .zc_gate_in  (auto_zero_cross_enable),
    .zc_in       (zc_right_in),
    .to_dis_in   (to_dis_in),
    .gain_out    (g_r)
  );

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  logic [7:0] lout_r, rout_r, lout_nxt, rout_nxt;
  logic       act_l_q_r, act_r_q_r;

  always_comb begin
    // manual gain when not controlled; register write wins
    lout_nxt = act_l ? g_l : ((act_l_q_r && lgain_nxt == lgain_r)
                               ? lout_r : lgain_nxt[CODE_HI:0]);
    rout_nxt = act_r ? g_r : ((act_r_q_r && rgain_nxt == rgain_r)
                               ? rout_r : rgain_nxt[CODE_HI:0]);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lout_r    <= CODE_0DB;
      rout_r    <= CODE_0DB;
      act_l_q_r <= 1'b1;
      act_r_q_r <= 1'b1;
    end else begin
      lout_r    <= lout_nxt;
      rout_r    <= rout_nxt;
      act_l_q_r <= act_l || (act_l_q_r && lgain_nxt == lgain_r);
      act_r_q_r <= act_r || (act_r_q_r && rgain_nxt == rgain_r);
    end
  end

  assign left_gain_code_out  = lout_r;
  assign right_gain_code_out = rout_r;
  assign cfg_one_out         = cfg1_r;
  assign cfg_two_out         = cfg2_r;
endmodule
`default_nettype wire

// ### testbench/agc_top_properties.sv
// assertion checker for the gain control top level
`timescale 1ns/10ps
`default_nettype none
module agc_top_properties
  import agc_pkg::*;
#(
  parameter int TO_CYC = ZC_TIMEOUT_CYC
) (
  input wire logic        clk_sys_in,          // system clock
  input wire logic        resetn_in,           // async reset, low
  input wire logic [15:0] ctrl_word_in,        // control word
  input wire logic        ctrl_strobe_in,      // write strobe
  input wire logic [23:0] peak_left_in,        // left peak
  input wire logic [23:0] peak_right_in,       // right peak
  input wire logic        zc_left_in,          // left zero cross
  input wire logic        zc_right_in,         // right zero cross
  input wire logic        to_dis_in,           // timeout off
  input wire logic [7:0]  left_gain_code_out,  // left gain
  input wire logic [7:0]  right_gain_code_out, // right gain
  input wire logic [8:0]  cfg_one_out,         // config one
  input wire logic [8:0]  cfg_two_out          // config two
);
  logic [6:0] addr;
  logic [2:0] stb_r;
  logic [2:0] stb_nxt;
  logic       quiet;
  // ----------------------------------------------------------------
  // strobe history: gains may jump for three cycles after any write
  // ----------------------------------------------------------------
  assign addr = ctrl_word_in[ADDR_HI:ADDR_LO];
  assign quiet = !ctrl_strobe_in && (stb_r == 3'b000);
  always_comb begin
    stb_nxt = {stb_r[1:0], ctrl_strobe_in};
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stb_r <= 3'b000;
    end else begin
      stb_r <= stb_nxt;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_CFG_ONE_WRITE: assert property (
    ctrl_strobe_in && addr == OFF_CFG_ONE
    |=> cfg_one_out == $past(ctrl_word_in[8:0]))
    else $error("config one readback wrong");
  AST_CFG_TWO_WRITE: assert property (
    ctrl_strobe_in && addr == OFF_CFG_TWO
    |=> cfg_two_out == $past(ctrl_word_in[8:0]))
    else $error("config two readback wrong");
  AST_SOFT_RESET: assert property (
    ctrl_strobe_in && addr == OFF_SOFT_RESET
    |=> cfg_one_out == RST_CFG_ONE && cfg_two_out == RST_CFG_TWO)
    else $error("soft reset left config changed");
  AST_CFG_HOLD: assert property (
    !(ctrl_strobe_in && (addr == OFF_CFG_ONE || addr == OFF_SOFT_RESET))
    |=> $stable(cfg_one_out))
    else $error("config one moved without a write");
  AST_LEFT_STEP: assert property (
    quiet && cfg_one_out[SEL_HI] && $past(cfg_one_out[SEL_HI])
    |-> (left_gain_code_out - $past(left_gain_code_out))
        inside {8'h00, 8'h01, 8'hff})
    else $error("left gain moved more than one code");
  AST_LEFT_FOLLOW: assert property (
    ctrl_strobe_in && addr == OFF_LEFT_GAIN && !cfg_one_out[SEL_HI]
    |=> left_gain_code_out == $past(ctrl_word_in[7:0]))
    else $error("idle left gain ignores its register");
  AST_RIGHT_FOLLOW: assert property (
    ctrl_strobe_in && addr == OFF_RIGHT_GAIN && !cfg_one_out[SEL_LO]
    |=> right_gain_code_out == $past(ctrl_word_in[7:0]))
    else $error("idle right gain ignores its register");
  AST_ALC_RANGE: assert property (
    quiet && !cfg_two_out[MODE_BIT] && cfg_one_out[SEL_LO]
    |-> right_gain_code_out >= CODE_MIN_PGA)
    else $error("alc right gain below pga range");
  AST_ZC_HOLD: assert property (
    quiet && !cfg_two_out[MODE_BIT] && cfg_two_out[ZC_BIT] && to_dis_in
    && cfg_one_out[SEL_LO] && !zc_right_in && !$past(zc_right_in)
    |=> $stable(right_gain_code_out))
    else $error("alc gain changed without zero cross");
endmodule
bind agc_top agc_top_properties #(.TO_CYC(TO_CYC)) agc_top_properties_i (
  .clk_sys_in, .resetn_in, .ctrl_word_in, .ctrl_strobe_in, .peak_left_in,
  .peak_right_in, .zc_left_in, .zc_right_in, .to_dis_in,
  .left_gain_code_out, .right_gain_code_out, .cfg_one_out, .cfg_two_out);
`default_nettype wire

// ### testbench/agc_top_tb.sv
// self-checking bench for the adc gain control block
`timescale 1ns/10ps
`default_nettype none
module agc_top_tb;
  import agc_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [15:0] ctrl_word_in = 16'h0000;
  logic        ctrl_strobe_in = 1'b0;
  logic [23:0] peak_left_in = 24'h000000;
  logic [23:0] peak_right_in = 24'h000000;
  logic        zc_left_in = 1'b0;
  logic        zc_right_in = 1'b0;
  logic        to_dis_in = 1'b1;
  logic [7:0]  left_gain_code_out;
  logic [7:0]  right_gain_code_out;
  logic [8:0]  cfg_one_out;
  logic [8:0]  cfg_two_out;
  int          failures = 0;
  int          check_count = 0;
  logic [8:0]  d;
  logic [7:0]  ls;
  logic [7:0]  rs;
  logic [7:0]  fl;

  always #12.5 clk_sys_in = ~clk_sys_in;

  // short timeout so a stalled zero cross resolves quickly
  agc_top #(.TO_CYC(64)) agc_top_i (
    .clk_sys_in, .resetn_in, .ctrl_word_in, .ctrl_strobe_in, .peak_left_in,
    .peak_right_in, .zc_left_in, .zc_right_in, .to_dis_in,
    .left_gain_code_out, .right_gain_code_out, .cfg_one_out, .cfg_two_out);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] v);
    @(posedge clk_sys_in);
    #1;
    ctrl_word_in = {a, v};
    ctrl_strobe_in = 1'b1;
    tick(1);
    ctrl_strobe_in = 1'b0;
  endtask
  task automatic cmp_cfg(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: config %h, want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_gain(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: gain %h, want %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] floor_of(input logic [7:0] s,
                                           input logic [3:0] c);
    return (c <= FLOOR_MIN) ? s - 8'h06 : s - {3'b000, c, 1'b0};
  endfunction
  // stops early if the gain leaves [lo, hi]
  task automatic wait_gain(input bit rt, input logic [7:0] t, lo, hi,
                           input int n);
    logic [7:0] g;
    for (int i = 0; i < n; i++) begin
      g = rt ? right_gain_code_out : left_gain_code_out;
      if (g == t || g < lo || g > hi) break;
      tick(1);
    end
    cmp_gain(g, t);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(16));
    tick(4);
    resetn_in = 1'b1;
    cmp_cfg(cfg_one_out, RST_CFG_ONE);
    cmp_cfg(cfg_two_out, RST_CFG_TWO);
    cmp_gain(left_gain_code_out, CODE_0DB);
    cmp_gain(right_gain_code_out, CODE_0DB);
    for (int i = 0; i < 6; i++) begin
      d = 9'($urandom);
      wr(OFF_CFG_ONE, d);
      cmp_cfg(cfg_one_out, d);
      wr(OFF_CFG_TWO, d & 9'h180);
      cmp_cfg(cfg_two_out, d & 9'h180);
      wr(7'h13, ~d);
      cmp_cfg(cfg_one_out, d);
      wr(OFF_SOFT_RESET, 9'($urandom));
      cmp_cfg(cfg_one_out, RST_CFG_ONE);
      cmp_cfg(cfg_two_out, RST_CFG_TWO);
    end
    // limiter on the left channel only
    wr(OFF_CFG_ONE, 9'h070);
    ls = 8'($urandom_range(8'hf0, 8'hc0));
    rs = 8'($urandom_range(8'hf0, 8'hc0));
    d = 9'($urandom_range(3, 0));
    wr(OFF_LEFT_GAIN, {1'b0, ls});
    cmp_gain(left_gain_code_out, ls);
    wr(OFF_TIMING, 9'h000);
    wr(OFF_ATTEN_CAP, d);
    fl = floor_of(ls, d[3:0]);
    peak_left_in = 24'h7fffff;
    peak_right_in = 24'h7fffff;
    wr(OFF_CFG_ONE, 9'h170);
    wait_gain(1'b0, fl, fl, ls, 20000);
    tick(2000);
    cmp_gain(left_gain_code_out, fl);
    wr(OFF_RIGHT_GAIN, {1'b0, rs});
    cmp_gain(right_gain_code_out, rs);
    peak_left_in = 24'h000000;
    wait_gain(1'b0, ls, fl, ls, 40000);
    tick(3000);
    cmp_gain(left_gain_code_out, ls);
    peak_left_in = 24'h7fffff;
    wait_gain(1'b0, ls - 8'h02, fl, ls, 5000);
    wr(OFF_CFG_ONE, 9'h070);
    tick(3000);
    cmp_gain(left_gain_code_out, ls - 8'h02);
    // alc on the right channel, zero cross gated
    wr(OFF_CFG_TWO, 9'h080);
    wr(OFF_RIGHT_GAIN, 9'h0cf);
    wr(OFF_CFG_ONE, 9'h0f0);
    tick(10000);
    cmp_gain(right_gain_code_out, CODE_0DB);
    zc_right_in = 1'b1;
    tick(1);
    zc_right_in = 1'b0;
    // two attack steps are pending when the crossing arrives
    wait_gain(1'b1, 8'hcd, 8'hcd, 8'hcf, 8);
    to_dis_in = 1'b0;
    wait_gain(1'b1, 8'hcc, 8'hcc, 8'hcd, 9000);
    wr(OFF_CFG_TWO, 9'h000);
    wait_gain(1'b1, 8'hcb, 8'hcb, 8'hcd, 9000);
    end_sim;
  end

  initial begin
    tick(90000);
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
